// [sim/stack_mem_model.sv]
`timescale 1ns/1ns
// ==========
// Core stack RAM seen from the push port
module stack_mem_model (
	input wire logic clk,
	input wire logic strobe,
	input wire logic [15:0] addr,
	input wire logic [2:0] index,
	output int count,
	output logic [15:0] last_addr,
	output logic [2:0] last_index
);
	// Keeps only a tally and the last slot written, enough to judge whole sequences
	initial count = 0;
	always @(posedge clk) begin
		if (strobe) begin
			count <= count + 1;
			last_addr <= addr;
			last_index <= index;
		end
	end
endmodule // stack_mem_model

// [sim/vector_unit_chk.sv]
`timescale 1ns/1ns
// ==========
// Port checks for the vector unit
module vector_unit_chk (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic VARIANT_B,
	input wire logic RESET_REQ,
	input wire vec_pkg::stack_op_t STACK_OP,
	input wire logic IRQ_PENDING,
	input wire logic [15:0] VEC_ADDR_HI,
	input wire logic [15:0] VEC_ADDR_LO,
	input wire logic STACK_BUSY,
	input wire logic [15:0] PUSH_ADDR,
	input wire logic PUSH_STROBE,
	input wire logic [15:0] STACK_PTR
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	lo_pairs_a: assert property (VEC_ADDR_LO == (VEC_ADDR_HI | 16'h0001))
		else $error("low vector byte not paired");
	vec_range_a: assert property (IRQ_PENDING |-> VEC_ADDR_HI >= 16'hFFCC && !VEC_ADDR_HI[0])
		else $error("vector outside the slot range");
	reset_top_a: assert property (RESET_REQ |=> VEC_ADDR_HI == 16'hFFFE)
		else $error("reset request not on top slot");
	no_resv_a: assert property (IRQ_PENDING && VARIANT_B |-> VEC_ADDR_HI >= 16'hFFD2 &&
		!(VEC_ADDR_HI inside {[16'hFFD4:16'hFFD9]}))
		else $error("reserved slot reported");
	int_seq_a: assert property (STACK_OP == vec_pkg::OP_INT && !STACK_BUSY |->
		##2 PUSH_STROBE [*5] ##1 !PUSH_STROBE) else $error("interrupt stacking not five bytes");
	call_seq_a: assert property (STACK_OP == vec_pkg::OP_CALL && !STACK_BUSY |->
		##2 PUSH_STROBE [*2] ##1 !PUSH_STROBE) else $error("call stacking not two bytes");
	push_dec_a: assert property (PUSH_STROBE && $past(PUSH_STROBE) |->
		PUSH_ADDR == $past(PUSH_ADDR) - 16'h0001) else $error("push address not descending");
	// Pull lands on the very next edge; a late or skipped pull fires here
	pull_inc_a: assert property (STACK_OP == vec_pkg::OP_PULL && !STACK_BUSY |=>
		STACK_PTR == $past(STACK_PTR) + 16'h0001) else $error("pull did not raise pointer");
	cover property (STACK_OP == vec_pkg::OP_INT && !STACK_BUSY);
	cover property (STACK_OP == vec_pkg::OP_CALL && !STACK_BUSY);
	cover property (RESET_REQ && IRQ_PENDING);
endmodule // vector_unit_chk
bind vector_unit vector_unit_chk u_vector_unit_chk (.CLK_SYS(CLK_SYS), .RST(RST),
	.VARIANT_B(VARIANT_B), .RESET_REQ(RESET_REQ), .STACK_OP(STACK_OP),
	.IRQ_PENDING(IRQ_PENDING), .VEC_ADDR_HI(VEC_ADDR_HI), .VEC_ADDR_LO(VEC_ADDR_LO),
	.STACK_BUSY(STACK_BUSY), .PUSH_ADDR(PUSH_ADDR), .PUSH_STROBE(PUSH_STROBE),
	.STACK_PTR(STACK_PTR));

// [sim/vector_unit_test.sv]
`timescale 1ns/1ns
// ==========
// Bench for the vector unit
module vector_unit_test;
	// Low address byte per source index 25..0; 00 means no slot in that map
	localparam logic [207:0] MAP_A = 208'h00D0D2D8D6D4E0DEDCDAE4E2E8EAE6CCCEEEF0F2F4ECF6F8FAFC;
	localparam logic [207:0] MAP_B = 208'hDCDED2E4E2E000000000E8E6000000ECEEF0F2F4F6EADAF8FAFC;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic variant_b = 1'b0;
	logic [31:0] irq_req = 32'h0;
	logic reset_req = 1'b0;
	vec_pkg::stack_op_t stack_op = vec_pkg::OP_NONE;
	logic irq_pending, stack_busy, push_strobe;
	logic [4:0] irq_source;
	logic [2:0] push_index, last_index;
	logic [15:0] vec_hi, vec_lo, push_addr, stack_ptr, last_addr;
	logic [15:0] sp_model = 16'h00FF;
	logic [207:0] map;
	int count;
	int err_count = 0;
	int comparisons = 0;
	vector_unit u_vector_unit (.CLK_SYS(clk_sys), .RST(rst), .VARIANT_B(variant_b),
		.IRQ_REQ(irq_req), .RESET_REQ(reset_req), .STACK_OP(stack_op),
		.IRQ_PENDING(irq_pending), .IRQ_SOURCE(irq_source), .VEC_ADDR_HI(vec_hi),
		.VEC_ADDR_LO(vec_lo), .STACK_BUSY(stack_busy), .PUSH_ADDR(push_addr),
		.PUSH_STROBE(push_strobe), .PUSH_INDEX(push_index), .STACK_PTR(stack_ptr));
	stack_mem_model u_stack_mem_model (.clk(clk_sys), .strobe(push_strobe),
		.addr(push_addr), .index(push_index), .count(count), .last_addr(last_addr),
		.last_index(last_index));
	// 25 MHz system clock
	initial forever #20 clk_sys = ~clk_sys;
	task automatic wrap_up;
		if (err_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Variant is only changed under reset, since it is meant to be static
	task automatic do_reset(input logic vb);
		rst = 1'b1;
		variant_b = vb;
		sp_model = 16'h00FF;
		wait_cyc(12);
		rst = 1'b0;
		wait_cyc(4);
		cmp16("stack pointer", 16'h00FF, stack_ptr);
		cmp16("source", 16'h001F, {11'h0, irq_source});
	endtask
	// Each source alone lands on its own slot or raises nothing
	task automatic scan_map;
		for (int i = 0; i < 26; i++) begin
			irq_req = 32'h1 << i;
			wait_cyc(5);
			cmp16("pending", {15'h0, map[8*i+:8] != 8'h00}, {15'h0, irq_pending});
			cmp16("source", (map[8*i+:8] != 8'h00) ? 16'(i) : 16'h001F, {11'h0, irq_source});
			if (map[8*i+:8] != 8'h00) begin
				cmp16("vector high", {8'hFF, map[8*i+:8]}, vec_hi);
				cmp16("vector low", {8'hFF, map[8*i+:8] | 8'h01}, vec_lo);
			end
		end
	endtask
	// Sources i..25 together grant the highest slot; reset request beats all
	task automatic scan_prio;
		logic [7:0] best;
		for (int i = 25; i >= 0; i--) begin
			best = 8'h00;
			for (int j = i; j < 26; j++) if (map[8*j+:8] > best) best = map[8*j+:8];
			irq_req = (32'h03FFFFFF >> i) << i;
			wait_cyc(5);
			if (best != 8'h00) cmp16("granted high", {8'hFF, best}, vec_hi);
		end
		reset_req = 1'b1;
		wait_cyc(2);
		cmp16("reset high", 16'hFFFE, vec_hi);
		cmp16("reset source", 16'h001F, {11'h0, irq_source});
		reset_req = 1'b0;
		irq_req = 32'h0;
		wait_cyc(5);
	endtask
	// One stack command; extra sends a call while busy, which must be ignored
	task automatic stack_cmd(input vec_pkg::stack_op_t op, input logic [15:0] n,
		input logic [15:0] delta, input logic extra);
		int c0;
		c0 = count;
		stack_op = op;
		wait_cyc(1);
		cmp16("busy", {15'h0, n > 16'h1}, {15'h0, stack_busy});
		stack_op = extra ? vec_pkg::OP_CALL : vec_pkg::OP_NONE;
		wait_cyc(1);
		stack_op = vec_pkg::OP_NONE;
		wait_cyc(10);
		cmp16("bytes pushed", n, 16'(count - c0));
		if (n != 16'h0) cmp16("last push", sp_model - n + 16'h1, last_addr);
		if (n != 16'h0) cmp16("last index", (n == 16'h1) ? 16'h0000 : 16'h0004, {13'h0, last_index});
		sp_model = sp_model - delta;
		cmp16("stack pointer", sp_model, stack_ptr);
	endtask
	// Hang guard, well beyond the expected run
	initial begin
		#800000;
		err_count++;
		wrap_up();
	end
	initial begin
		do_reset(1'b0);
		stack_cmd(vec_pkg::OP_INT, 16'h5, 16'h5, 1'b1);
		stack_cmd(vec_pkg::OP_CALL, 16'h2, 16'h2, 1'b0);
		stack_cmd(vec_pkg::OP_PUSH, 16'h1, 16'h1, 1'b0);
		stack_cmd(vec_pkg::OP_PULL, 16'h0, 16'hFFFF, 1'b0);
		stack_cmd(vec_pkg::OP_LOAD, 16'h0, 16'hFFF9, 1'b0);
		map = MAP_A;
		scan_map();
		scan_prio();
		do_reset(1'b1);
		map = MAP_B;
		scan_map();
		scan_prio();
		wrap_up();
	end
endmodule // vector_unit_test

// [src/stack_unit.sv]
`timescale 1ns/1ns
// Sixteen-bit stack pointer with interrupt and call push sequencing
module stack_unit (
	input wire logic clk,
	input wire logic rst,
	input wire vec_pkg::stack_op_t op,
	output logic busy,
	output logic [15:0] push_addr,
	output logic push_strobe,
	output logic [2:0] push_index,
	output logic [15:0] sp
);
	typedef struct packed {
		logic [15:0] sp;
		vec_pkg::seq_state_t st;
		logic [2:0] left;
		logic [2:0] idx;
		logic strobe;
		logic [15:0] addr;
	} state_t;
	state_t s_q, s_d;

	// ==========================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.strobe = 1'b0;
		case (s_q.st)
			vec_pkg::ST_IDLE: begin
				case (op)
					vec_pkg::OP_PUSH: begin
						s_d.addr = s_q.sp;
						s_d.strobe = 1'b1;
						s_d.idx = 3'h0;
						s_d.sp = s_q.sp - 16'h0001;
					end
					vec_pkg::OP_PULL: s_d.sp = s_q.sp + 16'h0001;
					vec_pkg::OP_LOAD: s_d.sp = vec_pkg::SP_RESET;
					// Five bytes; the high index byte has no slot at all
					vec_pkg::OP_INT: begin
						s_d.left = vec_pkg::INT_STACK_BYTES;
						s_d.idx = 3'h0;
						s_d.st = vec_pkg::ST_SEQ;
					end
					vec_pkg::OP_CALL: begin
						s_d.left = vec_pkg::CALL_STACK_BYTES;
						s_d.idx = 3'h0;
						s_d.st = vec_pkg::ST_SEQ;
					end
					default: ;
				endcase
			end
			vec_pkg::ST_SEQ: begin
				// One byte per clock, pointer moves down after each
				s_d.addr = s_q.sp;
				s_d.strobe = 1'b1;
				s_d.sp = s_q.sp - 16'h0001;
				s_d.idx = vec_pkg::INT_STACK_BYTES - s_q.left;
				s_d.left = s_q.left - 3'h1;
				if (s_q.left == 3'h1) begin
					s_d.st = vec_pkg::ST_IDLE;
				end
			end
			default: s_d.st = vec_pkg::ST_IDLE;
		endcase
	end

	// ==========================================
	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '{sp: vec_pkg::SP_RESET, st: vec_pkg::ST_IDLE, left: 3'h0, idx: 3'h0,
				strobe: 1'b0, addr: 16'h0000};
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = (s_q.st == vec_pkg::ST_SEQ);
	assign push_addr = s_q.addr;
	assign push_strobe = s_q.strobe;
	assign push_index = s_q.idx;
	assign sp = s_q.sp;
endmodule // stack_unit

// [src/vec_pkg.sv]
package vec_pkg;
	// ==========================================
	// Vector map
	localparam logic [15:0] VEC_BASE = 16'hFFCC; // Lowest slot
	localparam logic [15:0] VEC_RESET = 16'hFFFE; // Highest slot
	localparam int NUM_SLOTS = 26;
	localparam logic [4:0] SLOT_RESET = 5'h19;
	// ==========================================
	// Sources (one request bit each)
	localparam int NUM_SRC = 32;
	localparam logic [4:0] SRC_SOFT_INT = 5'h00;
	localparam logic [4:0] SRC_EXT = 5'h01;
	localparam logic [4:0] SRC_CLKGEN = 5'h02;
	localparam logic [4:0] SRC_PERIODIC = 5'h03;
	localparam logic [4:0] SRC_T1_OVF = 5'h04;
	localparam logic [4:0] SRC_T1_CH0 = 5'h05;
	localparam logic [4:0] SRC_T1_CH1 = 5'h06;
	localparam logic [4:0] SRC_T1_CH2 = 5'h07;
	localparam logic [4:0] SRC_T1_CH3 = 5'h08;
	localparam logic [4:0] SRC_T1_CH4 = 5'h09;
	localparam logic [4:0] SRC_T1_CH5 = 5'h0A;
	localparam logic [4:0] SRC_T2_OVF = 5'h0B;
	localparam logic [4:0] SRC_T2_CH0 = 5'h0C;
	localparam logic [4:0] SRC_T2_CH1 = 5'h0D;
	localparam logic [4:0] SRC_SPI_TX = 5'h0E;
	localparam logic [4:0] SRC_SPI_RX = 5'h0F;
	localparam logic [4:0] SRC_CAN_TX = 5'h10;
	localparam logic [4:0] SRC_CAN_RX = 5'h11;
	localparam logic [4:0] SRC_CAN_ERR = 5'h12;
	localparam logic [4:0] SRC_CAN_WAKE = 5'h13;
	localparam logic [4:0] SRC_SCI_TX = 5'h14;
	localparam logic [4:0] SRC_SCI_RX = 5'h15;
	localparam logic [4:0] SRC_SCI_ERR = 5'h16;
	localparam logic [4:0] SRC_KBD = 5'h17;
	localparam logic [4:0] SRC_ADC = 5'h18;
	localparam logic [4:0] SRC_LINK = 5'h19;
	localparam logic [4:0] SRC_NONE = 5'h1F; // Reserved slot marker
	// ==========================================
	// Stack
	localparam logic [15:0] SP_RESET = 16'h00FF;
	localparam logic [2:0] INT_STACK_BYTES = 3'h5;
	localparam logic [2:0] CALL_STACK_BYTES = 3'h2;
	// ==========================================
	// Stack operation commands
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_PUSH = 3'b001,
		OP_PULL = 3'b010,
		OP_LOAD = 3'b011, // reset_stack_pointer_instr
		OP_INT = 3'b100,
		OP_CALL = 3'b101
	} stack_op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEQ = 2'b01
	} seq_state_t;
endpackage

// [src/vector_unit.sv]
`timescale 1ns/1ns
// Interrupt vector map, priority and stacking for the core
module vector_unit (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic VARIANT_B,
	input wire logic [31:0] IRQ_REQ,
	input wire logic RESET_REQ,
	input wire vec_pkg::stack_op_t STACK_OP,
	output logic IRQ_PENDING,
	output logic [4:0] IRQ_SOURCE,
	output logic [15:0] VEC_ADDR_HI,
	output logic [15:0] VEC_ADDR_LO,
	output logic STACK_BUSY,
	output logic [15:0] PUSH_ADDR,
	output logic PUSH_STROBE,
	output logic [2:0] PUSH_INDEX,
	output logic [15:0] STACK_PTR
);
	// ==========================================
	// First variant map: slot k sits at FFCC + 2k, slot 25 (FFFE) is reset
	function automatic logic [4:0] slot_src_a(input logic [4:0] k);
		logic [4:0] r;
		r = vec_pkg::SRC_NONE;
		case (k)
			// First timer channels 5 and 4, then the converter
			5'h00: r = vec_pkg::SRC_T1_CH5; // FFCC
			5'h01: r = vec_pkg::SRC_T1_CH4; // FFCE
			5'h02: r = vec_pkg::SRC_ADC; // FFD0
			// Keyboard, then the asynchronous serial port
			5'h03: r = vec_pkg::SRC_KBD; // FFD2
			5'h04: r = vec_pkg::SRC_SCI_TX; // FFD4
			5'h05: r = vec_pkg::SRC_SCI_RX; // FFD6
			5'h06: r = vec_pkg::SRC_SCI_ERR; // FFD8
			// CAN controller
			5'h07: r = vec_pkg::SRC_CAN_TX; // FFDA
			5'h08: r = vec_pkg::SRC_CAN_RX; // FFDC
			5'h09: r = vec_pkg::SRC_CAN_ERR; // FFDE
			5'h0A: r = vec_pkg::SRC_CAN_WAKE; // FFE0
			// Synchronous serial port
			5'h0B: r = vec_pkg::SRC_SPI_TX; // FFE2
			5'h0C: r = vec_pkg::SRC_SPI_RX; // FFE4
			// Second timer
			5'h0D: r = vec_pkg::SRC_T2_OVF; // FFE6
			5'h0E: r = vec_pkg::SRC_T2_CH1; // FFE8
			5'h0F: r = vec_pkg::SRC_T2_CH0; // FFEA
			// First timer overflow and channels 3 down to 0, then periodic timer
			5'h10: r = vec_pkg::SRC_T1_OVF; // FFEC
			5'h11: r = vec_pkg::SRC_T1_CH3; // FFEE
			5'h12: r = vec_pkg::SRC_T1_CH2; // FFF0
			5'h13: r = vec_pkg::SRC_T1_CH1; // FFF2
			5'h14: r = vec_pkg::SRC_T1_CH0; // FFF4
			5'h15: r = vec_pkg::SRC_PERIODIC; // FFF6
			// Fixed top slots, the same in both variants
			5'h16: r = vec_pkg::SRC_CLKGEN; // FFF8
			5'h17: r = vec_pkg::SRC_EXT; // FFFA
			5'h18: r = vec_pkg::SRC_SOFT_INT; // FFFC
			default: r = vec_pkg::SRC_NONE;
		endcase
		return r;
	endfunction

	// ==========================================
	// Second variant map; SRC_NONE marks a reserved slot
	function automatic logic [4:0] slot_src_b(input logic [4:0] k);
		logic [4:0] r;
		r = vec_pkg::SRC_NONE;
		case (k)
			// Bottom three slots are reserved, so no source may land there
			5'h00: r = vec_pkg::SRC_NONE; // FFCC
			5'h01: r = vec_pkg::SRC_NONE; // FFCE
			5'h02: r = vec_pkg::SRC_NONE; // FFD0
			// Keyboard keeps its slot; the serial slots above it are empty here
			5'h03: r = vec_pkg::SRC_KBD; // FFD2
			5'h04: r = vec_pkg::SRC_NONE; // FFD4
			5'h05: r = vec_pkg::SRC_NONE; // FFD6
			5'h06: r = vec_pkg::SRC_NONE; // FFD8
			// Periodic timer, serial data link and converter take the first three CAN slots
			5'h07: r = vec_pkg::SRC_PERIODIC; // FFDA
			5'h08: r = vec_pkg::SRC_LINK; // FFDC
			5'h09: r = vec_pkg::SRC_ADC; // FFDE
			// Asynchronous serial port moves up
			5'h0A: r = vec_pkg::SRC_SCI_TX; // FFE0
			5'h0B: r = vec_pkg::SRC_SCI_RX; // FFE2
			5'h0C: r = vec_pkg::SRC_SCI_ERR; // FFE4
			// Synchronous serial port
			5'h0D: r = vec_pkg::SRC_SPI_TX; // FFE6
			5'h0E: r = vec_pkg::SRC_SPI_RX; // FFE8
			// First timer overflow, then channels 5 down to 0
			5'h0F: r = vec_pkg::SRC_T1_OVF; // FFEA
			5'h10: r = vec_pkg::SRC_T1_CH5; // FFEC
			5'h11: r = vec_pkg::SRC_T1_CH4; // FFEE
			5'h12: r = vec_pkg::SRC_T1_CH3; // FFF0
			5'h13: r = vec_pkg::SRC_T1_CH2; // FFF2
			5'h14: r = vec_pkg::SRC_T1_CH1; // FFF4
			5'h15: r = vec_pkg::SRC_T1_CH0; // FFF6
			// Fixed top slots, the same in both variants
			5'h16: r = vec_pkg::SRC_CLKGEN; // FFF8
			5'h17: r = vec_pkg::SRC_EXT; // FFFA
			5'h18: r = vec_pkg::SRC_SOFT_INT; // FFFC
			default: r = vec_pkg::SRC_NONE;
		endcase
		return r;
	endfunction

	typedef struct packed {
		logic [31:0] req_m1; // First request flop, read only by the second
		logic [31:0] req_q; // Settled requests
		logic [1:0] var_sync; // Strap goes through two flops
		logic variant;
		logic pend;
		logic [4:0] src;
		logic [15:0] hi;
	} state_t;
	state_t s_q, s_d;

	// ==========================================
	// Next state: synchronisers, then the priority scan
	always_comb begin
		logic [4:0] k;
		logic [4:0] sid;
		k = 5'h00;
		sid = vec_pkg::SRC_NONE;
		s_d = s_q;
		// Requests may come from other clocks, so two flops before the scan
		s_d.req_m1 = IRQ_REQ;
		s_d.req_q = s_q.req_m1;
		// Strap gets a third flop; the maps only ever see a settled value
		s_d.var_sync = {s_q.var_sync[0], VARIANT_B};
		s_d.variant = s_q.var_sync[1]; // Treated as static
		// Priority scan: later slots sit higher and overwrite earlier winners
		s_d.pend = 1'b0;
		s_d.src = vec_pkg::SRC_NONE;
		s_d.hi = vec_pkg::VEC_RESET;
		for (int i = 0; i < vec_pkg::NUM_SLOTS - 1; i++) begin
			k = 5'(i);
			sid = s_q.variant ? slot_src_b(k) : slot_src_a(k);
			// Reserved slots never win
			if (sid != vec_pkg::SRC_NONE && s_q.req_q[sid]) begin
				s_d.pend = 1'b1;
				s_d.src = sid;
				s_d.hi = vec_pkg::VEC_BASE + 16'({k, 1'b0});
			end
		end
		// Reset outranks every source
		if (RESET_REQ) begin
			s_d.pend = 1'b1;
			s_d.src = vec_pkg::SRC_NONE;
			s_d.hi = vec_pkg::VEC_RESET;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			s_q <= '{req_m1: 32'h00000000, req_q: 32'h00000000, var_sync: 2'b00,
				variant: 1'b0, pend: 1'b0, src: vec_pkg::SRC_NONE, hi: vec_pkg::VEC_RESET};
		end else begin
			s_q <= s_d;
		end
	end

	assign IRQ_PENDING = s_q.pend;
	assign IRQ_SOURCE = s_q.src;
	assign VEC_ADDR_HI = s_q.hi;
	assign VEC_ADDR_LO = s_q.hi | 16'h0001;

	// ==========================================
	// Stack pointer and push sequencing
	stack_unit u_stack (
		.clk(CLK_SYS),
		.rst(RST),
		.op(STACK_OP),
		.busy(STACK_BUSY),
		.push_addr(PUSH_ADDR),
		.push_strobe(PUSH_STROBE),
		.push_index(PUSH_INDEX),
		.sp(STACK_PTR)
	);
endmodule // vector_unit
